// file: rtl/rls_pkg.sv
// Package of constants for the receive lane status and statistics block
package rls_pkg;
  localparam int unsigned LANE_COUNT        = 12;
  localparam int unsigned FIRST_LANE        = 8;
  localparam int unsigned BIN_COUNT         = 7;
  localparam int unsigned LEN_WIDTH         = 15;
  localparam logic [7:0]  ADDR_CTRL         = 8'h00;
  localparam logic [7:0]  ADDR_OVERRIDE     = 8'h04;
  localparam logic [7:0]  ADDR_STATUS       = 8'h08;
  localparam logic [7:0]  ADDR_MARKER       = 8'h0C;
  localparam int unsigned CTRL_RX_TEST_BIT  = 0;
  localparam int unsigned CTRL_TX_TEST_BIT  = 1;
  localparam int unsigned CTRL_REPLACE_BIT  = 2;
  localparam int unsigned CTRL_MAXLEN_LSB   = 16;
  localparam int unsigned STAT_HIGH_ERR_BIT = 0;
  localparam int unsigned STAT_SIG_OS_BIT   = 1;
  localparam int unsigned STAT_FOUR_BIT     = 2;
  localparam int unsigned MARK_VALID_BIT    = 8;
  localparam logic [14:0] MAXLEN_RESET      = 15'h2580;
  localparam logic [7:0]  OVERRIDE_RESET    = 8'h00;
  localparam logic [14:0] LEN_64            = 15'h0040;
  localparam logic [14:0] LEN_127           = 15'h007F;
  localparam logic [14:0] LEN_255           = 15'h00FF;
  localparam logic [14:0] LEN_511           = 15'h01FF;
  localparam logic [14:0] LEN_1023          = 15'h03FF;
  localparam logic [14:0] LEN_1518          = 15'h05EE;
  localparam logic [14:0] LEN_1522          = 15'h05F2;
endpackage

// file: rtl/rls_lane_stats.sv
// Receive lane status, test pattern control and receive statistics increments
//
// Summary of operation
// [RULE1] Per-lane parity error flag, lanes 8 to 19
// [RULE2] High error rate level follows threshold
// [RULE3] Flag set when signal ordered-set seen
// [RULE4] Receive test enable starts idle pattern checking
// [RULE5] Transmit test enable sends scrambled idle pattern
// [RULE6] Mismatch count pulsed only while checking enabled
// [RULE7] Async lane-mode pin selects four or ten
// [RULE8] Replace lane-0 marker parity byte when enabled
// [RULE9] Present captured marker parity byte with valid
// [RULE10] Bytes received this cycle, seven bits
// [RULE11] Packets received this cycle, good or bad
// [RULE12] Good byte count only on clean completion
// [RULE13] Good packet pulse only on clean completion
// [RULE14] Checksum failure counted between 64 and maximum
// [RULE15] Size bins 64, 65-127, 128-255
// [RULE16] Size bins 256-511 through 1519-1522
// [RULE17] Lane error pulses one cycle, back-to-back allowed
// [RULE18] User supplies fifteen-bit maximum packet length
// [RULE19] Increments zero without a qualifying event
// [RULE20] One size bin per packet, at end; lengths below 64 or above 1522 get no bin
`timescale 1ns/1ps
module rls_lane_stats
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [11:0] lane_parity_bad,
  input  wire logic        error_rate_over,
  input  wire logic        signal_os_word,
  input  wire logic [2:0]  pattern_mismatch,
  input  wire logic        four_lane_select,
  input  wire logic [7:0]  tx_marker_parity_calc,
  input  wire logic [7:0]  marker_parity_rx,
  input  wire logic        marker_parity_strobe,
  input  wire logic [6:0]  rx_bytes,
  input  wire logic        pkt_end,
  input  wire logic [14:0] pkt_len,
  input  wire logic        pkt_fcs_bad,
  input  wire logic        pkt_other_err,
  output logic      [11:0] rx_lane_parity_error,
  output logic             rx_high_error_rate,
  output logic             rx_signal_ordered_set_seen,
  output logic             rx_test_check_enable,
  output logic             tx_idle_pattern_enable,
  output logic      [2:0]  rx_test_mismatch_count,
  output logic             four_lane_mode,
  output logic      [7:0]  tx_marker_parity_byte,
  output logic      [7:0]  rx_marker_parity_byte,
  output logic             rx_marker_parity_valid,
  output logic      [6:0]  rx_total_bytes_inc,
  output logic      [2:0]  rx_total_packets_inc,
  output logic      [13:0] rx_good_bytes_inc,
  output logic             rx_good_packets_inc,
  output logic             rx_checksum_fail_increment,
  output logic      [6:0]  rx_size_bin_inc
);

  // Bin index: 0=64, 1=65-127, 2=128-255, 3=256-511, 4=512-1023, 5=1024-1518, 6=1519-1522
  function automatic logic [6:0] rls_bin(input logic [14:0] len);
    logic [6:0] b;
    b = 7'h00;
    if (len == rls_pkg::LEN_64)
      b[0] = 1'b1;
    else if (len > rls_pkg::LEN_64 && len <= rls_pkg::LEN_127)
      b[1] = 1'b1;
    else if (len > rls_pkg::LEN_127 && len <= rls_pkg::LEN_255)
      b[2] = 1'b1;
    else if (len > rls_pkg::LEN_255 && len <= rls_pkg::LEN_511)
      b[3] = 1'b1;
    else if (len > rls_pkg::LEN_511 && len <= rls_pkg::LEN_1023)
      b[4] = 1'b1;
    else if (len > rls_pkg::LEN_1023 && len <= rls_pkg::LEN_1518)
      b[5] = 1'b1;
    else if (len > rls_pkg::LEN_1518 && len <= rls_pkg::LEN_1522)
      b[6] = 1'b1;
    return b;
  endfunction

  logic        rx_test_q;
  logic        tx_test_q;
  logic        replace_q;
  logic [14:0] max_len_q;
  logic [7:0]  override_q;
  logic        sig_os_q;
  logic        mode_meta_q;
  logic        mode_q;
  logic        mark_valid_q;
  logic [7:0]  mark_byte_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;
  logic        setup;
  logic        wr_access;
  logic        addr_ok;
  logic [31:0] rd_d;

  assign setup     = psel && !penable;
  assign wr_access = psel && penable && pwrite && pready_q;
  assign addr_ok   = (paddr == rls_pkg::ADDR_CTRL) || (paddr == rls_pkg::ADDR_OVERRIDE) ||
                     (paddr == rls_pkg::ADDR_STATUS) || (paddr == rls_pkg::ADDR_MARKER);

  always_comb
  begin
    rd_d = 32'h0000_0000;
    unique case (paddr)
      rls_pkg::ADDR_CTRL:
      begin
        rd_d[rls_pkg::CTRL_RX_TEST_BIT] = rx_test_q;
        rd_d[rls_pkg::CTRL_TX_TEST_BIT] = tx_test_q;
        rd_d[rls_pkg::CTRL_REPLACE_BIT] = replace_q;
        rd_d[rls_pkg::CTRL_MAXLEN_LSB +: rls_pkg::LEN_WIDTH] = max_len_q;
      end
      rls_pkg::ADDR_OVERRIDE:
        rd_d[7:0] = override_q;
      rls_pkg::ADDR_STATUS:
      begin
        rd_d[rls_pkg::STAT_HIGH_ERR_BIT] = rx_high_error_rate;
        rd_d[rls_pkg::STAT_SIG_OS_BIT]   = sig_os_q;
        rd_d[rls_pkg::STAT_FOUR_BIT]     = mode_q;
      end
      rls_pkg::ADDR_MARKER:
      begin
        rd_d[7:0]                      = mark_byte_q;
        rd_d[rls_pkg::MARK_VALID_BIT]  = mark_valid_q;
      end
      default:
        rd_d = 32'h0000_0000;
    endcase
  end

  // Answer is prepared in the setup cycle so the access phase never waits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end
    else if (ce)
    begin
      pready_q  <= setup;
      pslverr_q <= setup && !addr_ok;
      if (setup && !pwrite)
        prdata_q <= rd_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_test_q  <= 1'b0;
      tx_test_q  <= 1'b0;
      replace_q  <= 1'b0;
      max_len_q  <= rls_pkg::MAXLEN_RESET;
      override_q <= rls_pkg::OVERRIDE_RESET;
    end
    else if (ce && wr_access)
    begin
      if (paddr == rls_pkg::ADDR_CTRL)
      begin
        rx_test_q <= pwdata[rls_pkg::CTRL_RX_TEST_BIT];   // [RULE4]
        tx_test_q <= pwdata[rls_pkg::CTRL_TX_TEST_BIT];   // [RULE5]
        replace_q <= pwdata[rls_pkg::CTRL_REPLACE_BIT];   // [RULE8]
        max_len_q <= pwdata[rls_pkg::CTRL_MAXLEN_LSB +: rls_pkg::LEN_WIDTH];
      end
      if (paddr == rls_pkg::ADDR_OVERRIDE)
        override_q <= pwdata[7:0];
    end
  end

  // Sticky signal ordered-set flag; a new sighting wins over a write-one clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sig_os_q <= 1'b0;
    else if (ce)
    begin
      if (signal_os_word)
        sig_os_q <= 1'b1;                                 // [RULE3]
      else if (wr_access && paddr == rls_pkg::ADDR_STATUS && pwdata[rls_pkg::STAT_SIG_OS_BIT])
        sig_os_q <= 1'b0;
    end
  end

  // Lane mode pin is static but asynchronous, so it is synchronised before use
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_meta_q <= 1'b0;
      mode_q      <= 1'b0;
    end
    else if (ce)
    begin
      mode_meta_q <= four_lane_select;
      mode_q      <= mode_meta_q;                         // [RULE7]
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mark_valid_q <= 1'b0;
      mark_byte_q  <= 8'h00;
    end
    else if (ce && marker_parity_strobe)
    begin
      mark_valid_q <= 1'b1;                               // [RULE9]
      mark_byte_q  <= marker_parity_rx;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_lane_parity_error       <= 12'h000;
      rx_high_error_rate         <= 1'b0;
      rx_signal_ordered_set_seen <= 1'b0;
      rx_test_check_enable       <= 1'b0;
      tx_idle_pattern_enable     <= 1'b0;
      rx_test_mismatch_count     <= 3'h0;
      four_lane_mode             <= 1'b0;
      tx_marker_parity_byte      <= 8'h00;
      rx_marker_parity_byte      <= 8'h00;
      rx_marker_parity_valid     <= 1'b0;
    end
    else if (ce)
    begin
      rx_lane_parity_error       <= lane_parity_bad;      // [RULE1] [RULE17]
      rx_high_error_rate         <= error_rate_over;      // [RULE2]
      rx_signal_ordered_set_seen <= sig_os_q || signal_os_word;  // [RULE3]
      rx_test_check_enable       <= rx_test_q;            // [RULE4]
      tx_idle_pattern_enable     <= tx_test_q;            // [RULE5]
      rx_test_mismatch_count     <= rx_test_q ? pattern_mismatch : 3'h0;  // [RULE6]
      four_lane_mode             <= mode_q;               // [RULE7]
      tx_marker_parity_byte      <= replace_q ? override_q : tx_marker_parity_calc;  // [RULE8]
      rx_marker_parity_byte      <= mark_byte_q;          // [RULE9]
      rx_marker_parity_valid     <= mark_valid_q;
    end
  end

  // Statistics: every increment is zero unless its event occurs this cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_total_bytes_inc         <= 7'h00;
      rx_total_packets_inc       <= 3'h0;
      rx_good_bytes_inc          <= 14'h0000;
      rx_good_packets_inc        <= 1'b0;
      rx_checksum_fail_increment <= 1'b0;
      rx_size_bin_inc            <= 7'h00;
    end
    else if (ce)
    begin
      rx_total_bytes_inc   <= rx_bytes;                   // [RULE10]
      rx_total_packets_inc <= {2'b00, pkt_end};           // [RULE11] [RULE19]
      rx_good_packets_inc  <= pkt_end && !pkt_fcs_bad && !pkt_other_err;  // [RULE13]
      rx_good_bytes_inc    <= (pkt_end && !pkt_fcs_bad && !pkt_other_err) ? pkt_len[13:0] : 14'h0000;  // [RULE12]
      // Upper bound comes from software's maximum packet length
      rx_checksum_fail_increment <= pkt_end && pkt_fcs_bad && pkt_len >= rls_pkg::LEN_64 &&
                                    pkt_len <= max_len_q;  // [RULE14] [RULE18]
      rx_size_bin_inc      <= pkt_end ? rls_bin(pkt_len) : 7'h00;  // [RULE15] [RULE16] [RULE20]
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_lane_pulse;
    ce |=> rx_lane_parity_error == $past(lane_parity_bad);
  endproperty
  a_lane_pulse: assert property (p_lane_pulse) else $error("lane error not mirrored");  // [RULE1]

  property p_lane_one_cycle;
    ce && lane_parity_bad[0] ##1 ce && !lane_parity_bad[0] |=> !rx_lane_parity_error[0];
  endproperty
  a_lane_one_cycle: assert property (p_lane_one_cycle) else $error("lane pulse stretched");  // [RULE17]

  property p_high_rate;
    ce |=> rx_high_error_rate == $past(error_rate_over);
  endproperty
  a_high_rate: assert property (p_high_rate) else $error("error rate level wrong");  // [RULE2]

  property p_sig_os;
    ce && signal_os_word |=> rx_signal_ordered_set_seen && sig_os_q;
  endproperty
  a_sig_os: assert property (p_sig_os) else $error("ordered-set flag missed");  // [RULE3]

  property p_mismatch_gate;
    ce && !rx_test_q |=> rx_test_mismatch_count == 3'h0;
  endproperty
  a_mismatch_gate: assert property (p_mismatch_gate) else $error("mismatch while disabled");  // [RULE6]

  property p_mode;
    ce [*3] |=> four_lane_mode == $past(four_lane_select, 3);
  endproperty
  a_mode: assert property (p_mode) else $error("lane mode not followed");  // [RULE7]

  property p_replace;
    ce && replace_q |=> tx_marker_parity_byte == $past(override_q);
  endproperty
  a_replace: assert property (p_replace) else $error("override byte not used");  // [RULE8]

  property p_marker;
    ce && marker_parity_strobe ##1 ce |=> rx_marker_parity_valid && rx_marker_parity_byte == $past(marker_parity_rx, 2);
  endproperty
  a_marker: assert property (p_marker) else $error("marker byte not presented");  // [RULE9]

  property p_good;
    ce && pkt_end && (pkt_fcs_bad || pkt_other_err) |=> !rx_good_packets_inc && rx_good_bytes_inc == 14'h0000;
  endproperty
  a_good: assert property (p_good) else $error("bad packet counted good");  // [RULE13]

  property p_idle_zero;
    ce && !pkt_end |=> rx_size_bin_inc == 7'h00 && rx_total_packets_inc == 3'h0 && !rx_checksum_fail_increment;
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("increment without packet");  // [RULE19]

  property p_one_bin;
    ce |=> $onehot0(rx_size_bin_inc);
  endproperty
  a_one_bin: assert property (p_one_bin) else $error("packet in two bins");  // [RULE20]

  property p_fcs_short;
    ce && pkt_end && pkt_len < rls_pkg::LEN_64 |=> !rx_checksum_fail_increment;
  endproperty
  a_fcs_short: assert property (p_fcs_short) else $error("runt counted as checksum fail");  // [RULE14]

  c_good_pkt: cover property (ce && pkt_end && !pkt_fcs_bad && !pkt_other_err ##1 rx_good_packets_inc);
  c_fcs_fail: cover property (ce && rx_checksum_fail_increment);
  c_back_to_back: cover property (rx_lane_parity_error[3] ##1 rx_lane_parity_error[3]);
  c_replace: cover property (ce && replace_q ##1 tx_marker_parity_byte != 8'h00);

endmodule

// file: test/rls_user_acc.sv
// User-side accumulator adding the total byte, total packet, checksum fail and size bin increments
`timescale 1ns/1ps
module rls_user_acc
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [6:0]  byte_inc,
  input  wire logic [2:0]  pkt_inc,
  input  wire logic        fail_inc,
  input  wire logic [6:0]  bin_inc,
  output logic      [31:0] byte_sum,
  output logic      [31:0] pkt_sum,
  output logic      [31:0] fail_sum,
  output logic      [31:0] bin_sum
);
  // No qualifier on purpose: idle cycles must add nothing
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      byte_sum <= '0;
      pkt_sum  <= '0;
      fail_sum <= '0;
      bin_sum  <= '0;
    end
    else
    begin
      byte_sum <= byte_sum + 32'(byte_inc);
      pkt_sum  <= pkt_sum + 32'(pkt_inc);
      fail_sum <= fail_sum + 32'(fail_inc);
      // Counting set bits exposes a packet landing in two bins
      bin_sum  <= bin_sum + 32'($countones(bin_inc));
    end
  end
endmodule

// file: test/rls_lane_stats_tb_top.sv
// Self-checking bench for the receive lane status and statistics block
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module rls_lane_stats_tb_top;
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, error_rate_over, signal_os_word;
  logic        four_lane_select, marker_parity_strobe, pkt_end, pkt_fcs_bad, pkt_other_err;
  logic [7:0]  paddr, tx_marker_parity_calc, marker_parity_rx, tx_marker_parity_byte, rx_marker_parity_byte;
  logic [31:0] pwdata, prdata, byte_sum, pkt_sum, fail_sum, bin_sum, sb, sp, sf, sn;
  logic [11:0] lane_parity_bad, rx_lane_parity_error;
  logic [2:0]  pattern_mismatch, rx_test_mismatch_count, rx_total_packets_inc;
  logic [6:0]  rx_bytes, rx_total_bytes_inc, rx_size_bin_inc;
  logic [14:0] pkt_len, maxl;
  logic [13:0] rx_good_bytes_inc;
  logic        rx_high_error_rate, rx_signal_ordered_set_seen, rx_test_check_enable, tx_idle_pattern_enable;
  logic        four_lane_mode, rx_marker_parity_valid, rx_good_packets_inc, rx_checksum_fail_increment;
  logic        rxt, rep, armed;
  logic [7:0]  ovr;
  logic [56:0] cur;
  logic [56:0] q[$];
  int          err_count, checks_done;
  logic [14:0] lens[16] = '{15'h003F, 15'h0040, 15'h0041, 15'h007F, 15'h0080, 15'h00FF, 15'h0100, 15'h01FF,
                            15'h0200, 15'h03FF, 15'h0400, 15'h05DC, 15'h05DD, 15'h05EE, 15'h05F2, 15'h05F3};

  rls_lane_stats DUT (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .lane_parity_bad, .error_rate_over, .signal_os_word, .pattern_mismatch, .four_lane_select,
    .tx_marker_parity_calc, .marker_parity_rx, .marker_parity_strobe, .rx_bytes, .pkt_end, .pkt_len,
    .pkt_fcs_bad, .pkt_other_err, .rx_lane_parity_error, .rx_high_error_rate, .rx_signal_ordered_set_seen,
    .rx_test_check_enable, .tx_idle_pattern_enable, .rx_test_mismatch_count, .four_lane_mode,
    .tx_marker_parity_byte, .rx_marker_parity_byte, .rx_marker_parity_valid, .rx_total_bytes_inc,
    .rx_total_packets_inc, .rx_good_bytes_inc, .rx_good_packets_inc, .rx_checksum_fail_increment,
    .rx_size_bin_inc);

  rls_user_acc ACC (.pclk, .presetn, .byte_inc(rx_total_bytes_inc), .pkt_inc(rx_total_packets_inc),
    .fail_inc(rx_checksum_fail_increment), .bin_inc(rx_size_bin_inc), .byte_sum, .pkt_sum, .fail_sum, .bin_sum);

  function automatic logic [6:0] bin_of(input logic [14:0] l);
    if (l < 15'h0040 || l > 15'h05F2) return 7'h00;
    if (l == 15'h0040) return 7'h01;
    if (l <= 15'h007F) return 7'h02;
    if (l <= 15'h00FF) return 7'h04;
    if (l <= 15'h01FF) return 7'h08;
    if (l <= 15'h03FF) return 7'h10;
    if (l <= 15'h05EE) return 7'h20;
    return 7'h40;
  endfunction

  task automatic print_verdict();
    if (err_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // x holds the expected error flag above the expected read data
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] x);
    int k;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1)
    begin
      err_count++;
      print_verdict();
    end
    `CHK("apb_error", x[32], pslverr)
    if (!w) `CHK("apb_rdata", x[31:0], prdata)
    {psel, penable} <= 2'b00;
  endtask

  // Last cycle drives zeros so the idle outputs are checked too
  task automatic traffic(input int n);
    logic [31:0] r, s;
    logic [14:0] l;
    logic        g, f;
    for (int i = 0; i <= n; i++)
    begin
      @(posedge pclk);
      r = (i < n) ? $urandom : 32'h0;
      s = (i < n) ? $urandom : 32'h0;
      l = lens[s[13:10]];
      g = s[7] & ~s[8] & ~s[9];
      f = s[7] & s[8] & (l >= 15'h0040) & (l <= maxl);
      {lane_parity_bad, error_rate_over, pattern_mismatch, tx_marker_parity_calc} <= r[23:0];
      {rx_bytes, pkt_end, pkt_fcs_bad, pkt_other_err, pkt_len} <= {s[6:0], s[7], s[8], s[9], l};
      q.push_back({r[23:11], rxt ? r[10:8] : 3'h0, rep ? ovr : r[7:0], s[6:0], 2'h0, s[7],
                   g ? l[13:0] : 14'h0, g, f, s[7] ? bin_of(l) : 7'h00});
      sb += 32'(s[6:0]);
      sp += 32'(s[7]);
      sf += 32'(f);
      sn += (s[7] && bin_of(l) != 7'h00) ? 32'h1 : 32'h0;
    end
  endtask

  always @(posedge pclk)
  begin
    #1;
    if (armed)
    begin
      `CHK("lane_status", cur[56:33], {rx_lane_parity_error, rx_high_error_rate, rx_test_mismatch_count,
           tx_marker_parity_byte})
      `CHK("rx_stats", cur[32:0], {rx_total_bytes_inc, rx_total_packets_inc, rx_good_bytes_inc,
           rx_good_packets_inc, rx_checksum_fail_increment,
           rx_size_bin_inc})
    end
    armed = (q.size() > 0);
    if (armed) cur = q.pop_front();
  end

  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  initial
  begin
    repeat (60000) @(posedge pclk);
    err_count++;
    print_verdict();
  end

  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, lane_parity_bad, error_rate_over, signal_os_word} = '0;
    {pattern_mismatch, four_lane_select, tx_marker_parity_calc, marker_parity_rx, marker_parity_strobe} = '0;
    {rx_bytes, pkt_end, pkt_len, pkt_fcs_bad, pkt_other_err, sb, sp, sf, sn, rxt, rep, ovr, armed} = '0;
    {err_count, checks_done} = '0;
    ce = 1'b1;
    maxl = 15'h2580;
    void'($urandom(66));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0, {1'b0, 32'h2580_0000});
    apb(1'b0, 8'h0C, 32'h0, {1'b0, 32'h0000_0000});
    apb(1'b0, 8'h10, 32'h0, {1'b1, 32'h0000_0000});
    traffic(300);
    // Tighter maximum length puts the 1500-byte boundary inside the table
    apb(1'b1, 8'h00, 32'h05DC_0007, 33'h0);
    apb(1'b1, 8'h04, 32'h0000_00A5, 33'h0);
    {maxl, rxt, rep, ovr} = {15'h05DC, 2'b11, 8'hA5};
    repeat (2) @(posedge pclk);
    `CHK("test_enables", 2'b11, {rx_test_check_enable, tx_idle_pattern_enable})
    traffic(300);
    // Let the zero cycle of the traffic be sampled before the level inputs move
    @(posedge pclk);
    {signal_os_word, four_lane_select, error_rate_over, marker_parity_rx, marker_parity_strobe} <= 12'hF3D;
    @(posedge pclk);
    {signal_os_word, marker_parity_rx, marker_parity_strobe} <= 10'h1FE;
    repeat (5) @(posedge pclk);
    `CHK("os_flag", 1'b1, rx_signal_ordered_set_seen)
    `CHK("four_mode", 1'b1, four_lane_mode)
    `CHK("marker", 9'h19E, {rx_marker_parity_valid, rx_marker_parity_byte})
    apb(1'b0, 8'h08, 32'h0, {1'b0, 32'h0000_0007});
    apb(1'b0, 8'h0C, 32'h0, {1'b0, 32'h0000_019E});
    apb(1'b1, 8'h08, 32'h0000_0002, 33'h0);
    apb(1'b0, 8'h08, 32'h0, {1'b0, 32'h0000_0005});
    `CHK("os_cleared", 1'b0, rx_signal_ordered_set_seen)
    // A sighting while the enable is low must not reach the sticky flag
    @(posedge pclk);
    {ce, signal_os_word} <= 2'b01;
    repeat (3) @(posedge pclk);
    `CHK("ce_freeze", 1'b0, rx_signal_ordered_set_seen)
    {ce, signal_os_word} <= 2'b10;
    repeat (2) @(posedge pclk);
    `CHK("acc", {sb, sp, sf, sn}, {byte_sum, pkt_sum, fail_sum, bin_sum})
    print_verdict();
  end
endmodule
